// ===== rtl/sxa_cfg_regs.sv
// Port configuration slice: identity, indirect window, error header and uncorrectable status
`timescale 1ns/1ps
`include "sxa_regs.svh"

module sxa_cfg_regs #(
    parameter int BYTES = 4
) (
    input  wire logic                 core_clk_in,
    input  wire logic                 srst_in,
    input  wire logic                 hot_rst_in,
    input  wire logic                 lock_wr_en_in,
    input  wire logic                 surprise_down_report_capable_in,
    input  wire logic [31:0]          uncorrectable_error_mask_in,
    input  wire sxa_pkg::sxa_cfg_req_t cfg_req_in,
    input  wire sxa_pkg::sxa_err_evt_t err_evt_in,
    output sxa_pkg::sxa_cfg_rsp_t     cfg_rsp_out,
    output logic [31:0]               uncorrectable_error_status_out,
    output logic                      err_report_out
);
    import sxa_pkg::*;

    // =========================================================
    // Elaboration checks
    // =========================================================
    if (BYTES != 4) begin : g_bad_width
        $error("sxa_cfg_regs serves 32-bit registers only");
    end

    // =========================================================
    // State
    // =========================================================
    logic [31:0]  ident_ff;
    logic [31:0]  nxt_ident;
    logic [31:0]  win_addr_ff;
    logic [31:0]  nxt_win_addr;
    logic [11:0]  nxt_ptr_ff;
    logic [11:0]  nxt_nxt_ptr;
    logic [31:0]  sts_ff;
    logic [31:0]  nxt_sts;
    logic         lock_meta_ff;
    logic         lock_ff;
    sxa_cfg_rsp_t rsp_ff;
    sxa_cfg_rsp_t nxt_rsp;
    logic         report_ff;
    logic         nxt_report;

    // =========================================================
    // Lock strap synchroniser
    // =========================================================
    // The lock comes from a pin, so it is settled before any write logic sees it
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            lock_meta_ff <= 1'b0;
            lock_ff      <= 1'b0;
        end else begin
            lock_meta_ff <= lock_wr_en_in;
            lock_ff      <= lock_meta_ff;
        end
    end

    // =========================================================
    // Target selection
    // =========================================================
    wire [11:0] req_byte_addr;
    wire        hit_win_data;
    wire [11:0] win_byte_addr;
    wire        win_self;
    wire        win_blocked;
    wire [11:0] tgt_addr;
    wire        sel_ident;
    wire        sel_win_addr;
    wire        sel_err_cap;
    wire        sel_sts;

    assign req_byte_addr = {cfg_req_in.dw_addr, 2'b00};
    assign hit_win_data  = req_byte_addr == `SXA_OFS_WIN_DATA;
    assign win_byte_addr = {win_addr_ff[11:2], 2'b00};
    // Data window pointing at itself reaches nothing
    assign win_self      = win_byte_addr == `SXA_OFS_WIN_DATA;
    // Side-band has no path through the window at all
    assign win_blocked   = hit_win_data && (cfg_req_in.smbus || win_self);
    assign tgt_addr      = hit_win_data ? win_byte_addr : req_byte_addr;

    assign sel_ident     = !win_blocked && (tgt_addr == `SXA_OFS_IDENT);
    assign sel_win_addr  = !win_blocked && (tgt_addr == `SXA_OFS_WIN_ADDR);
    assign sel_err_cap   = !win_blocked && (tgt_addr == `SXA_OFS_ERR_CAP);
    assign sel_sts       = !win_blocked && (tgt_addr == `SXA_OFS_UNC_STS);

    // =========================================================
    // Byte enables
    // =========================================================
    wire [31:0] be_bits;
    wire        wr_go;

    for (genvar b = 0; b < BYTES; b++) begin : g_be
        assign be_bits[8*b +: 8] = {8{cfg_req_in.byte_en[b]}};
    end

    assign wr_go = cfg_req_in.valid && cfg_req_in.write;

    // =========================================================
    // Read view of each register
    // =========================================================
    wire [31:0] err_cap_view;
    wire [31:0] sts_view;
    wire [31:0] rd_word;

    assign err_cap_view = {nxt_ptr_ff, `SXA_CAP_VER, `SXA_CAP_ID};
    // Hardwired zero bits are forced here as well as never being set
    assign sts_view     = sts_ff & `SXA_STS_W1C_MASK;

    assign rd_word = sel_ident    ? ident_ff :
                     sel_win_addr ? (win_addr_ff & `SXA_WIN_ADDR_MASK) :
                     sel_err_cap  ? err_cap_view :
                     sel_sts      ? sts_view :
                                    32'h0000_0000;

    // =========================================================
    // Write merges
    // =========================================================
    wire [31:0] ident_merge;
    wire [31:0] win_addr_merge;
    wire [31:0] cap_merge;
    wire [31:0] sts_clear;

    assign ident_merge    = (ident_ff & ~be_bits) | (cfg_req_in.wdata & be_bits);
    assign win_addr_merge = ((win_addr_ff & ~be_bits) | (cfg_req_in.wdata & be_bits))
                            & `SXA_WIN_ADDR_MASK;
    assign cap_merge      = (err_cap_view & ~be_bits) | (cfg_req_in.wdata & be_bits);
    assign sts_clear      = cfg_req_in.wdata & be_bits & `SXA_STS_W1C_MASK;

    // =========================================================
    // Error events
    // =========================================================
    logic [31:0] evt_bits;
    wire  [31:0] evt_logged;

    always_comb begin
        evt_bits = 32'h0000_0000;
        evt_bits[`SXA_BIT_DLP]       = err_evt_in.link_protocol_error_flag;
        // Surprise down is only ever logged on a port that can report it
        evt_bits[`SXA_BIT_SDN]       = err_evt_in.surprise_down_flag
                                       && surprise_down_report_capable_in;
        evt_bits[`SXA_BIT_POISON]    = err_evt_in.poisoned_tlp_flag;
        evt_bits[`SXA_BIT_FCP]       = err_evt_in.flow_control_error_flag;
        evt_bits[`SXA_BIT_UNEXP_CPL] = err_evt_in.unexpected_completion_flag;
        evt_bits[`SXA_BIT_RCV_OVR]   = err_evt_in.receive_overflow_flag;
        evt_bits[`SXA_BIT_MALFORMED] = err_evt_in.bad_format_tlp_flag;
        evt_bits[`SXA_BIT_ECRC]      = err_evt_in.ecrc_error_flag;
        evt_bits[`SXA_BIT_UNSUP_REQ] = err_evt_in.unsupported_request_flag;
    end

    // Bit 0 has no event source, so it can only ever hold zero after reset
    assign evt_logged = evt_bits & ~uncorrectable_error_mask_in
                        & `SXA_STS_W1C_MASK;

    // =========================================================
    // Next state
    // =========================================================
    always_comb begin
        nxt_ident    = ident_ff;
        nxt_win_addr = win_addr_ff;
        nxt_nxt_ptr  = nxt_ptr_ff;
        nxt_sts      = sts_ff;
        if (wr_go && lock_ff && sel_ident) begin
            nxt_ident = ident_merge;
        end
        if (wr_go && sel_win_addr) begin
            nxt_win_addr = win_addr_merge;
        end
        if (wr_go && lock_ff && sel_err_cap) begin
            nxt_nxt_ptr = cap_merge[31:`SXA_NXT_PTR_LSB];
        end
        if (wr_go && sel_sts) begin
            nxt_sts = sts_ff & ~sts_clear;
        end
        // A new event wins over a clear in the same cycle
        nxt_sts = nxt_sts | evt_logged;
    end

    always_comb begin
        nxt_rsp.valid = cfg_req_in.valid;
        nxt_rsp.rdata = (cfg_req_in.valid && !cfg_req_in.write) ? rd_word
                                                                : 32'h0000_0000;
        nxt_report    = |evt_logged;
    end

    // =========================================================
    // Registers returned to their reset values by any reset
    // =========================================================
    always_ff @(posedge core_clk_in) begin
        if (srst_in || hot_rst_in) begin
            ident_ff    <= `SXA_IDENT_RST;
            win_addr_ff <= `SXA_WIN_ADDR_RST;
            nxt_ptr_ff  <= `SXA_NXT_PTR_RST;
            rsp_ff      <= '0;
            report_ff   <= 1'b0;
        end else begin
            ident_ff    <= nxt_ident;
            win_addr_ff <= nxt_win_addr;
            nxt_ptr_ff  <= nxt_nxt_ptr;
            rsp_ff      <= nxt_rsp;
            report_ff   <= nxt_report;
        end
    end

    // =========================================================
    // Sticky status, cleared only by the fundamental reset
    // =========================================================
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            sts_ff <= `SXA_STS_RST;
        end else begin
            sts_ff <= nxt_sts;
        end
    end

    // =========================================================
    // Outputs
    // =========================================================
    assign cfg_rsp_out                    = rsp_ff;
    assign uncorrectable_error_status_out = sts_ff;
    assign err_report_out                 = report_ff;

endmodule : sxa_cfg_regs

// ===== common/sxa_regs.svh
// Offsets, field positions, reset values and fixed codes of the port configuration slice
`ifndef SXA_REGS_SVH
`define SXA_REGS_SVH
`define SXA_OFS_IDENT       12'h0F4
`define SXA_OFS_WIN_ADDR    12'h0F8
`define SXA_OFS_WIN_DATA    12'h0FC
`define SXA_OFS_ERR_CAP     12'h100
`define SXA_OFS_UNC_STS     12'h104
`define SXA_IDENT_RST       32'h0000_0000
`define SXA_WIN_ADDR_RST    32'h0000_0000
`define SXA_WIN_ADDR_MASK   32'h0000_0FFC
`define SXA_CAP_ID          16'h0001
`define SXA_CAP_VER         4'h1
`define SXA_NXT_PTR_RST     12'h200
`define SXA_NXT_PTR_LSB     20
`define SXA_STS_RST         32'h0000_0000
`define SXA_STS_W1C_MASK    32'h001F_3031
`define SXA_BIT_UNUSED      0
`define SXA_BIT_DLP         4
`define SXA_BIT_SDN         5
`define SXA_BIT_POISON      12
`define SXA_BIT_FCP         13
`define SXA_BIT_UNEXP_CPL   16
`define SXA_BIT_RCV_OVR     17
`define SXA_BIT_MALFORMED   18
`define SXA_BIT_ECRC        19
`define SXA_BIT_UNSUP_REQ   20
`endif

// ===== common/sxa_pkg.sv
// Types shared by the port configuration slice and its users
package sxa_pkg;
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        smbus;
        logic [11:2] dw_addr;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } sxa_cfg_req_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] rdata;
    } sxa_cfg_rsp_t;

    typedef struct packed {
        logic link_protocol_error_flag;
        logic surprise_down_flag;
        logic poisoned_tlp_flag;
        logic flow_control_error_flag;
        logic unexpected_completion_flag;
        logic receive_overflow_flag;
        logic bad_format_tlp_flag;
        logic ecrc_error_flag;
        logic unsupported_request_flag;
    } sxa_err_evt_t;
endpackage : sxa_pkg

// ===== sim/sxa_cfg_regs_chk.sv
// Concurrent checks on the port configuration slice
`timescale 1ns/1ps
module sxa_cfg_regs_chk #(parameter int BYTES = 4) (
    input wire logic                  core_clk_in,
    input wire logic                  srst_in,
    input wire logic                  hot_rst_in,
    input wire logic                  lock_wr_en_in,
    input wire logic                  surprise_down_report_capable_in,
    input wire logic [31:0]           uncorrectable_error_mask_in,
    input wire sxa_pkg::sxa_cfg_req_t cfg_req_in,
    input wire sxa_pkg::sxa_err_evt_t err_evt_in,
    input wire sxa_pkg::sxa_cfg_rsp_t cfg_rsp_out,
    input wire logic [31:0]           uncorrectable_error_status_out,
    input wire logic                  err_report_out
);
    import sxa_pkg::*;
    // ====
    // Events mapped onto status positions
    wire [8:0]  e   = err_evt_in;
    wire        cap = surprise_down_report_capable_in;
    wire [31:0] ev  = {11'h0, e[0], e[1], e[2], e[3], e[4], 2'b0, e[5], e[6], 6'h0,
                       e[7] & cap, e[8], 4'h0};
    wire [31:0] hit = ev & ~uncorrectable_error_mask_in;
    wire [31:0] st  = uncorrectable_error_status_out;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (srst_in);
    sequence s_req(w, s, a);
        cfg_req_in.valid && cfg_req_in.write == w && cfg_req_in.smbus == s
            && cfg_req_in.dw_addr == a;
    endsequence
    // ====
    // Properties
    a_rsp_next_cycle: assert property (disable iff (srst_in || hot_rst_in)
        cfg_req_in.valid |=> cfg_rsp_out.valid) else $error("response missing");
    a_fixed_zero_bits: assert property ((st & ~32'h001F_3031) == 0)
        else $error("fixed status bit set");
    a_event_logged: assert property (hit != 0 |=> (st & $past(hit)) == $past(hit))
        else $error("event not logged");
    a_no_spurious_set: assert property ((st & ~$past(st) & ~$past(hit)) == 0)
        else $error("status bit set without cause");
    a_sdn_gated: assert property (!cap && !st[5] |=> !st[5])
        else $error("surprise down logged while incapable");
    a_report_pulse: assert property (!$past(srst_in) && !$past(hot_rst_in)
        |-> err_report_out == ($past(hit) != 0)) else $error("report mismatch");
    a_w1c_clear: assert property (s_req(1, 0, 10'h041) ##0 cfg_req_in.byte_en == 4'hF
        && ev == 0 |=> (st & $past(cfg_req_in.wdata)) == 0) else $error("clear failed");
    a_clear_by_one: assert property (!$past(srst_in) && (~st & $past(st)) != 0
        |-> $past(cfg_req_in.valid && cfg_req_in.write)
            && (~st & $past(st) & ~$past(cfg_req_in.wdata)) == 0) else $error("bit lost");
    a_cap_header: assert property (disable iff (srst_in || hot_rst_in)
        s_req(0, 0, 10'h040) |=> cfg_rsp_out.rdata[19:0] == 20'h1_0001)
        else $error("header code wrong");
    a_smbus_window: assert property (disable iff (srst_in || hot_rst_in)
        s_req(0, 1, 10'h03F) |=> cfg_rsp_out.rdata == 0) else $error("side-band read");
endmodule : sxa_cfg_regs_chk

bind sxa_cfg_regs sxa_cfg_regs_chk #(.BYTES(BYTES)) u_chk (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .hot_rst_in(hot_rst_in),
    .lock_wr_en_in(lock_wr_en_in),
    .surprise_down_report_capable_in(surprise_down_report_capable_in),
    .uncorrectable_error_mask_in(uncorrectable_error_mask_in), .cfg_req_in(cfg_req_in),
    .err_evt_in(err_evt_in), .cfg_rsp_out(cfg_rsp_out),
    .uncorrectable_error_status_out(uncorrectable_error_status_out),
    .err_report_out(err_report_out));

// ===== sim/sxa_rc_model.sv
// Root complex model issuing one configuration request at a time
`timescale 1ns/1ps
module sxa_rc_model (
    input  wire logic                  core_clk_in,
    input  wire sxa_pkg::sxa_cfg_rsp_t cfg_rsp_in,
    output sxa_pkg::sxa_cfg_req_t      cfg_req_out
);
    import sxa_pkg::*;
    initial cfg_req_out = '0;
    // ====
    // Request pulse; released fields are inverted so stale data is never trusted
    task automatic cfg(input logic smb, input logic wr, input logic [9:0] a,
                       input logic [3:0] be, input logic [31:0] wd, output logic [31:0] rd);
        rd = 'x;
        @(posedge core_clk_in);
        cfg_req_out <= '{valid: 1'b1, write: wr, smbus: smb, dw_addr: a, byte_en: be, wdata: wd};
        @(posedge core_clk_in);
        cfg_req_out <= {1'b0, ~cfg_req_out[47:0]};
        // The answer stands for one cycle only, so it is taken at the edge that ends it
        @(posedge core_clk_in);
        if (cfg_rsp_in.valid) rd = cfg_rsp_in.rdata;
    endtask : cfg
endmodule : sxa_rc_model

// ===== sim/sxa_cfg_regs_tb_top.sv
// Self-checking bench for the port configuration slice
`timescale 1ns/1ps
module sxa_cfg_regs_tb_top;
    import sxa_pkg::*;
    logic         clk = 1'b0, srst = 1'b1, hot_rst = 1'b0, lock = 1'b0, sd_cap = 1'b0;
    logic [31:0]  mask = '0, sts, rd, m_ident = '0, m_addr = '0, m_sts = '0;
    logic [11:0]  m_nxt = 12'h200;
    sxa_err_evt_t evt = '0;
    sxa_cfg_req_t req;
    sxa_cfg_rsp_t rsp;
    logic         rpt;
    int           n_mismatch = 0, n_tests = 0, cyc = 0;
    int           sb[9] = '{20, 19, 18, 17, 16, 13, 12, 5, 4};
    sxa_cfg_regs #(.BYTES(4)) dut (.core_clk_in(clk), .srst_in(srst), .hot_rst_in(hot_rst),
        .lock_wr_en_in(lock), .surprise_down_report_capable_in(sd_cap),
        .uncorrectable_error_mask_in(mask), .cfg_req_in(req), .err_evt_in(evt),
        .cfg_rsp_out(rsp), .uncorrectable_error_status_out(sts), .err_report_out(rpt));
    sxa_rc_model u_rc (.core_clk_in(clk), .cfg_rsp_in(rsp), .cfg_req_out(req));
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            final_report();
        end
    end
    // ====
    // Reference model and checks
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_tests++;
        if (got !== want) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, want);
        end
    endtask : chk
    function automatic logic [31:0] mrd(input logic [9:0] a);
        case (a)
            10'h03D: return m_ident;
            10'h03E: return m_addr;
            10'h040: return {m_nxt, 20'h1_0001};
            10'h041: return m_sts;
            default: return 32'h0000_0000;
        endcase
    endfunction : mrd
    task automatic acc(input logic smb, input logic wr, input logic [9:0] a,
                       input logic [3:0] be, input logic [31:0] wd);
        logic [9:0]  t;
        logic [31:0] bm, v;
        t  = (a == 10'h03F) ? (smb ? 10'h03F : m_addr[11:2]) : a;
        bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        v  = (mrd(t) & ~bm) | (wd & bm);
        u_rc.cfg(smb, wr, a, be, wd, rd);
        chk(rd, (wr || t == 10'h03F) ? 32'h0000_0000 : mrd(t));
        if (wr && t == 10'h03D && lock) m_ident = v;
        if (wr && t == 10'h03E) m_addr = v & 32'h0000_0FFC;
        if (wr && t == 10'h040 && lock) m_nxt = v[31:20];
        if (wr && t == 10'h041) m_sts &= ~(wd & bm);
    endtask : acc
    task automatic rdall();
        for (int a = 'h3D; a <= 'h42; a++) acc(1'b0, 1'b0, 10'(a), 4'hF, 32'h0000_0000);
    endtask : rdall
    task automatic fire(input int j, input logic [31:0] m, input logic c);
        logic h;
        @(posedge clk);
        mask   <= m;
        sd_cap <= c;
        evt    <= sxa_err_evt_t'(9'h001 << j);
        @(posedge clk);
        evt <= '0;
        #1;
        h = !mask[sb[j]] && (sb[j] != 5 || sd_cap);
        if (h) m_sts[sb[j]] = 1'b1;
        chk(sts, m_sts);
        chk(32'(rpt), 32'(h));
    endtask : fire
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report
    // ====
    // Main sequence
    initial begin
        void'($urandom(32'h0000_664C));
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rdall();
        acc(1'b0, 1'b1, 10'h03D, 4'hF, $urandom);
        acc(1'b0, 1'b1, 10'h040, 4'hF, 32'hFFFF_FFFF);
        @(posedge clk);
        lock <= 1'b1;
        repeat (3) @(posedge clk);
        acc(1'b0, 1'b1, 10'h03D, 4'hF, $urandom);
        acc(1'b0, 1'b1, 10'h03D, 4'b0101, $urandom);
        acc(1'b0, 1'b1, 10'h040, 4'b1100, $urandom);
        acc(1'b0, 1'b1, 10'h03E, 4'hF, 32'hFFFF_FFFF);
        for (int j = 0; j < 9; j++) fire(j, 32'h0000_0000, 1'b0);
        acc(1'b0, 1'b1, 10'h041, 4'hF, 32'h0000_0000);
        acc(1'b0, 1'b1, 10'h041, 4'hF, 32'hFFFF_FFFF);
        for (int j = 0; j < 9; j++) fire(j, $urandom, 1'b1);
        acc(1'b0, 1'b1, 10'h041, 4'($urandom), $urandom);
        for (int i = 0; i < 6; i++) begin
            acc(1'b0, 1'b1, 10'h03E, 4'hF, {20'h0, 10'h03D + 10'(i), 2'b0});
            acc(1'b0, 1'b0, 10'h03F, 4'hF, 32'h0000_0000);
            acc(1'b1, 1'b1, 10'h03F, 4'hF, $urandom);
            acc(1'b0, 1'b1, 10'h03F, 4'($urandom), $urandom);
            acc(1'b1, 1'b0, 10'h03F, 4'hF, 32'h0000_0000);
            rdall();
        end
        for (int j = 0; j < 9; j++) fire(j, 32'h0000_0000, 1'b1);
        @(posedge clk);
        hot_rst <= 1'b1;
        repeat (2) @(posedge clk);
        hot_rst <= 1'b0;
        m_ident = '0;
        m_addr  = '0;
        m_nxt   = 12'h200;
        rdall();
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst  <= 1'b0;
        m_sts = '0;
        rdall();
        final_report();
    end
endmodule : sxa_cfg_regs_tb_top
